// *** rtl/pwr_mode_pkg.sv ***
`default_nettype none
package pwr_mode_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] SYS_CLK_CTRL_OFS = 8'h00;
  localparam logic [7:0] HS_OSC_CTRL_OFS  = 8'h04;
  localparam logic [7:0] PWR_STATUS_OFS   = 8'h08;
  localparam logic [7:0] PORTA_WAKE_OFS   = 8'h0c;
  localparam logic [7:0] MODE_STATE_OFS   = 8'h10;

  // ------------------------------------------------------------
  // Fields
  // ------------------------------------------------------------
  localparam int SEL_MSB     = 7;
  localparam int SEL_LSB     = 5;
  localparam int HS_KEEP_BIT = 1;
  localparam int LS_KEEP_BIT = 0;
  localparam int FSEL_MSB    = 3;
  localparam int FSEL_LSB    = 2;
  localparam int HS_STB_BIT  = 1;
  localparam int HS_EN_BIT   = 0;
  localparam int PDF_BIT     = 0;
  localparam int TO_BIT      = 1;

  localparam logic [2:0] SEL_SUB      = 3'h7;
  localparam logic [2:0] SEL_RST      = 3'h0;
  localparam logic [1:0] KEEP_RST     = 2'h0;
  localparam logic [1:0] FSEL_RST     = 2'h0;
  localparam logic       HS_EN_RST    = 1'b1;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int HS_STAB_NS    = 1000;
  localparam int HS_STAB_CYC   = (HS_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Modes and states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_PDOWN = 3'b010,
    ST_WAKE  = 3'b100
  } pm_state_t;
endpackage
`default_nettype wire

// *** rtl/power_mode_switch_wakeup.sv ***
// Contract
// - Select value 111 moves the system clock to the low-speed sub clock.
// - Select values 000..110 run the system clock at high-speed divided by 1..64.
// - Switch into low-speed mode completes only once the low-speed oscillator is stable.
// - Return to high-speed waits for restart and stable flag of the high-speed oscillator.
// - Halt with both keep-on bits 0 enters sleep: clock stops, watchdog only.
// - Halt with high keep 0, low keep 1 stops high clock, keeps sub clock.
// - Halt with both keep-on bits 1 keeps both clocks, execution stops.
// - Halt with high keep 1, low keep 0 keeps high clock, stops sub clock; here the sub clock stays on while the watchdog is enabled.
// - Power-down entry preserves memory, registers and port states.
// - Power-down entry sets power-down flag and clears watchdog timeout flag.
// - Halt clears watchdog counter; it counts only if watchdog enabled.
// - Wake on enabled Port A falling edge, interrupt, or watchdog overflow.
// - Power-down flag clears on power-up or clear-watchdog instruction.
// - Watchdog wake sets timeout flag, resets only program counter and stack pointer.
// - Port A pins individually enabled for wake; resume after the halt.
// - Disabled interrupt or full stack: resume after halt, service deferred.
// - Enabled interrupt with free stack level: normal interrupt response on wake.
// - Interrupt already requested before entry is no wake source that period.
// - High-speed stable flag clears on enable or frequency change, sets when stable.
// - Select field in bits 7..5, keep-on bits at 1 and 0 of clock control.
//
// Design decisions made here: the APB slave port and the register offsets.
`default_nettype none
module power_mode_switch_wakeup
  import pwr_mode_pkg::*;
#(
  parameter int PORTA_W  = 8,
  parameter int IRQ_W    = 8,
  parameter int STAB_CYC = HS_STAB_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic               ce_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               halt_i,
  input  wire logic               clr_wdt_i,
  input  wire logic               wdt_enable_i,
  input  wire logic               wdt_overflow_i,
  input  wire logic [IRQ_W-1:0]   irq_req_i,
  input  wire logic [IRQ_W-1:0]   irq_en_i,
  input  wire logic               stack_full_i,
  input  wire logic [PORTA_W-1:0] porta_i,
  input  wire logic               hs_osc_ready_i,
  input  wire logic               ls_osc_ready_i,
  input  wire logic               ls_clk_i,
  output logic                    hs_osc_en_o,
  output logic                    ls_osc_en_o,
  output logic [1:0]              hs_freq_sel_o,
  output logic                    sys_clk_tick_o,
  output logic                    cpu_run_o,
  output logic                    io_hold_o,
  output logic                    wdt_clear_o,
  output logic                    wdt_run_o,
  output logic                    pc_sp_reset_o,
  output logic                    irq_service_o,
  output logic                    resume_o,
  output logic                    power_down_flag_o,
  output logic                    wdt_timeout_flag_o
);

  // Wake enables fit one bus word; the stable counter needs a nonzero span
  if (PORTA_W < 1 || PORTA_W > 32 || IRQ_W < 1 || STAB_CYC < 1) begin : g_bad_param
    $error("power_mode_switch_wakeup: unsupported parameter");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [PORTA_W-1:0] pa_s1_r, pa_s2_r, pa_s3_r;
  logic [2:0]         osc_s1_r, osc_s2_r;
  logic               lsclk_d_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pa_s1_r   <= '1;
      pa_s2_r   <= '1;
      pa_s3_r   <= '1;
      osc_s1_r  <= 3'h0;
      osc_s2_r  <= 3'h0;
      lsclk_d_r <= 1'b0;
    end else if (ce_i) begin
      pa_s1_r   <= porta_i;
      pa_s2_r   <= pa_s1_r;
      pa_s3_r   <= pa_s2_r;
      osc_s1_r  <= {ls_clk_i, ls_osc_ready_i, hs_osc_ready_i};
      osc_s2_r  <= osc_s1_r;
      lsclk_d_r <= osc_s2_r[2];
    end
  end

  logic hs_ready, ls_ready, ls_tick;
  assign hs_ready = osc_s2_r[0];
  assign ls_ready = osc_s2_r[1];
  assign ls_tick  = osc_s2_r[2] & ~lsclk_d_r;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [2:0]         sel_r;
  logic [1:0]         keep_r;
  logic [1:0]         fsel_r;
  logic               hs_en_r;
  logic [PORTA_W-1:0] pa_wake_en_r;
  logic               pdf_r, to_r;
  pm_state_t          state_r;

  logic wr_en, setup;
  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pwrite_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_r        <= SEL_RST;
      keep_r       <= KEEP_RST;
      fsel_r       <= FSEL_RST;
      hs_en_r      <= HS_EN_RST;
      pa_wake_en_r <= '0;
    end else if (ce_i && wr_en) begin
      case (paddr_i)
        SYS_CLK_CTRL_OFS: begin
          sel_r  <= pwdata_i[SEL_MSB:SEL_LSB];
          keep_r <= {pwdata_i[HS_KEEP_BIT], pwdata_i[LS_KEEP_BIT]};
        end
        HS_OSC_CTRL_OFS: begin
          fsel_r  <= pwdata_i[FSEL_MSB:FSEL_LSB];
          hs_en_r <= pwdata_i[HS_EN_BIT];
        end
        PORTA_WAKE_OFS: pa_wake_en_r <= pwdata_i[PORTA_W-1:0];
        default: ;
      endcase
    end
  end

  logic mapped;
  always_comb begin
    mapped = 1'b1;
    case (paddr_i)
      SYS_CLK_CTRL_OFS, HS_OSC_CTRL_OFS, PWR_STATUS_OFS, PORTA_WAKE_OFS, MODE_STATE_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  logic        hs_stable_r;
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    case (paddr_i)
      SYS_CLK_CTRL_OFS: begin
        rd_val[SEL_MSB:SEL_LSB] = sel_r;
        rd_val[HS_KEEP_BIT]     = keep_r[1];
        rd_val[LS_KEEP_BIT]     = keep_r[0];
      end
      HS_OSC_CTRL_OFS: begin
        rd_val[FSEL_MSB:FSEL_LSB] = fsel_r;
        rd_val[HS_STB_BIT]        = hs_stable_r;
        rd_val[HS_EN_BIT]         = hs_en_r;
      end
      PWR_STATUS_OFS: begin
        rd_val[PDF_BIT] = pdf_r;
        rd_val[TO_BIT]  = to_r;
      end
      PORTA_WAKE_OFS: rd_val[PORTA_W-1:0] = pa_wake_en_r;
      MODE_STATE_OFS: rd_val[2:0] = state_r;
      default: rd_val = 32'h0;
    endcase
  end

  // Read data captured in setup so the access cycle answers from a flop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (ce_i && setup) begin
      prdata_o  <= pwrite_i ? 32'h0 : rd_val;
      pslverr_o <= ~mapped;
    end
  end
  assign pready_o = 1'b1;

  // ------------------------------------------------------------
  // High-speed oscillator control and stable flag
  // ------------------------------------------------------------
  logic        pd, hs_need, hs_on_d_r;
  logic [1:0]  fsel_d_r;
  logic [$clog2(STAB_CYC+1)-1:0] stab_cnt_r;

  assign pd = (state_r == ST_PDOWN);
  // Fast mode needs the high clock even when software cleared its enable
  assign hs_need     = pd ? keep_r[1] : (hs_en_r | (sel_r != SEL_SUB));
  assign hs_osc_en_o = hs_need;
  assign ls_osc_en_o = pd ? (keep_r[0] | wdt_enable_i) : 1'b1;
  assign hs_freq_sel_o = fsel_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hs_on_d_r   <= 1'b0;
      fsel_d_r    <= FSEL_RST;
      hs_stable_r <= 1'b0;
      stab_cnt_r  <= '0;
    end else if (ce_i) begin
      hs_on_d_r <= hs_need;
      fsel_d_r  <= fsel_r;
      if (!hs_need || (hs_need && !hs_on_d_r) || fsel_r != fsel_d_r) begin
        hs_stable_r <= 1'b0;
        stab_cnt_r  <= '0;
      end else if (!hs_stable_r && hs_ready) begin
        if (stab_cnt_r == ($clog2(STAB_CYC+1))'(STAB_CYC - 1)) begin
          hs_stable_r <= 1'b1;
        end else begin
          stab_cnt_r <= stab_cnt_r + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // System clock source and divider
  // ------------------------------------------------------------
  logic [2:0] act_sel_r;
  logic [5:0] div_cnt_r;
  logic [5:0] div_mask;
  logic       act_sub;

  assign act_sub = (act_sel_r == SEL_SUB);

  // Applied selection follows at once between dividers, else only once the target source is stable
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      act_sel_r <= SEL_RST;
    end else if (ce_i && sel_r != act_sel_r) begin
      if (sel_r == SEL_SUB) begin
        if (ls_ready) begin
          act_sel_r <= sel_r;
        end
      end else if (act_sub) begin
        if (hs_stable_r) begin
          act_sel_r <= sel_r;
        end
      end else begin
        act_sel_r <= sel_r;
      end
    end
  end

  always_comb begin
    div_mask = 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (i < int'(act_sel_r)) begin
        div_mask[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_cnt_r <= 6'h00;
    end else if (ce_i) begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  // System clock stops in every power-down mode
  assign sys_clk_tick_o = ce_i & (state_r == ST_RUN) &
                          (act_sub ? ls_tick : ((div_cnt_r & div_mask) == 6'h00));

  // ------------------------------------------------------------
  // Wake sources
  // ------------------------------------------------------------
  logic [IRQ_W-1:0] irq_block_r;
  logic [IRQ_W-1:0] irq_new;
  logic             pa_wake, irq_wake, wake;

  assign pa_wake  = |(pa_s3_r & ~pa_s2_r & pa_wake_en_r);
  assign irq_new  = irq_req_i & ~irq_block_r;
  assign irq_wake = |irq_new;
  assign wake     = pa_wake | irq_wake | wdt_overflow_i;

  // ------------------------------------------------------------
  // Power-mode sequencer
  // ------------------------------------------------------------
  logic src_ok;
  logic by_wdt_r, by_irq_r;
  logic [IRQ_W-1:0] wake_irq_r;

  assign src_ok = act_sub ? ls_ready : hs_stable_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r     <= ST_RUN;
      irq_block_r <= '0;
      by_wdt_r    <= 1'b0;
      by_irq_r    <= 1'b0;
      wake_irq_r  <= '0;
    end else if (ce_i) begin
      case (state_r)
        ST_RUN: begin
          if (halt_i) begin
            state_r     <= ST_PDOWN;
            irq_block_r <= irq_req_i;
            by_wdt_r    <= 1'b0;
            by_irq_r    <= 1'b0;
          end
        end
        ST_PDOWN: begin
          if (wake) begin
            state_r    <= ST_WAKE;
            by_wdt_r   <= wdt_overflow_i;
            by_irq_r   <= irq_wake;
            wake_irq_r <= irq_new;
          end
        end
        ST_WAKE: begin
          if (src_ok) begin
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Memory, registers and port drivers stay frozen while the CPU is off
  assign io_hold_o = (state_r != ST_RUN);
  assign cpu_run_o = (state_r == ST_RUN);
  assign wdt_run_o = wdt_enable_i;

  // ------------------------------------------------------------
  // Status flags and wake-up pulses
  // ------------------------------------------------------------
  logic entry, done;
  assign entry = ce_i & (state_r == ST_RUN) & halt_i;
  assign done  = ce_i & (state_r == ST_WAKE) & src_ok;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pdf_r <= 1'b0;
      to_r  <= 1'b0;
    end else if (ce_i) begin
      if (entry) begin
        pdf_r <= 1'b1;
        to_r  <= 1'b0;
      end else begin
        if (clr_wdt_i) begin
          pdf_r <= 1'b0;
        end
        if (state_r == ST_PDOWN && wdt_overflow_i) begin
          to_r <= 1'b1;
        end
      end
    end
  end
  assign power_down_flag_o  = pdf_r;
  assign wdt_timeout_flag_o = to_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wdt_clear_o   <= 1'b0;
      pc_sp_reset_o <= 1'b0;
      irq_service_o <= 1'b0;
      resume_o      <= 1'b0;
    end else if (ce_i) begin
      wdt_clear_o   <= entry;
      // Watchdog wake takes priority: only PC and SP are reset
      pc_sp_reset_o <= done & by_wdt_r;
      irq_service_o <= done & ~by_wdt_r & by_irq_r &
                       (|(wake_irq_r & irq_en_i)) & ~stack_full_i;
      resume_o      <= done & ~by_wdt_r &
                       (~by_irq_r | ~(|(wake_irq_r & irq_en_i)) | stack_full_i);
    end
  end

endmodule
`default_nettype wire

// *** sim/pwr_wake_checker.sv ***
`default_nettype none
module pwr_wake_checker (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic halt_i,
  input wire logic clr_wdt_i,
  input wire logic wdt_overflow_i,
  input wire logic cpu_run_o,
  input wire logic io_hold_o,
  input wire logic wdt_clear_o,
  input wire logic pc_sp_reset_o,
  input wire logic irq_service_o,
  input wire logic resume_o,
  input wire logic power_down_flag_o,
  input wire logic wdt_timeout_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_halt;
    cpu_run_o && ce_i && halt_i;
  endsequence
  sequence s_wake;
    pc_sp_reset_o || irq_service_o || resume_o;
  endsequence

  AST_HALT_CLR: assert property (s_halt |=> wdt_clear_o)
    else $error("watchdog not cleared on halt");
  AST_CLR_ONCE: assert property (!cpu_run_o && ce_i |=> !wdt_clear_o)
    else $error("watchdog clear outside halt");
  AST_HALT_FLAGS: assert property (s_halt |=> power_down_flag_o && !wdt_timeout_flag_o)
    else $error("flags wrong on entry");
  AST_HALT_STOP: assert property (s_halt |=> !cpu_run_o && io_hold_o)
    else $error("core not held on entry");
  AST_PD_HOLD: assert property (power_down_flag_o && !clr_wdt_i |=> power_down_flag_o)
    else $error("power-down flag lost");
  AST_PD_CLR: assert property (clr_wdt_i && ce_i && !(cpu_run_o && halt_i) |=> !power_down_flag_o)
    else $error("power-down flag not cleared");
  AST_TMO_SET: assert property (s_halt ##1 (wdt_overflow_i && ce_i) |=> wdt_timeout_flag_o)
    else $error("timeout flag not set");
  AST_ONE_PULSE: assert property ($onehot0({pc_sp_reset_o, irq_service_o, resume_o}))
    else $error("several wake pulses");
  AST_WAKE_RUN: assert property (s_wake |-> $rose(cpu_run_o))
    else $error("wake pulse without restart");
endmodule

bind power_mode_switch_wakeup pwr_wake_checker u_chk (.*);
`default_nettype wire

// *** sim/osc_model.sv ***
`default_nettype none
module osc_model #(
  parameter int RDY_CYC = 6
) (
  input  wire logic clk_i,
  input  wire logic hs_en_i,
  input  wire logic ls_en_i,
  output logic      hs_ready_o,
  output logic      ls_ready_o,
  output logic      ls_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int hs_cnt = 0;
  int ls_cnt = 0;

  // Ready only after a start-up delay, lost at once when stopped
  always @(posedge clk_i) begin
    hs_cnt <= hs_en_i ? hs_cnt + (hs_cnt < RDY_CYC) : 0;
    ls_cnt <= ls_en_i ? ls_cnt + (ls_cnt < RDY_CYC) : 0;
  end
  assign hs_ready_o = hs_en_i && (hs_cnt == RDY_CYC);
  assign ls_ready_o = ls_en_i && (ls_cnt == RDY_CYC);

  // Sub clock stands still while stopped; 16 cycles per period
  initial begin
    ls_clk_o = 1'b0;
    #13;
    forever #400 if (ls_en_i) ls_clk_o = ~ls_clk_o;
  end
endmodule
`default_nettype wire

// *** sim/power_mode_switch_wakeup_tb.sv ***
`default_nettype none
module power_mode_switch_wakeup_tb import pwr_mode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] keep;
    logic       we;
    logic [2:0] wk;
    logic       hs;
    logic       ls;
    logic [2:0] pl;
  } row_t;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        halt_i = 1'b0;
  logic        clr_wdt_i = 1'b0;
  logic        wdt_enable_i = 1'b0;
  logic        wdt_overflow_i = 1'b0;
  logic [7:0]  irq_req_i = 8'h00;
  logic [7:0]  irq_en_i = 8'h00;
  logic        stack_full_i = 1'b0;
  logic [7:0]  porta_i = 8'hff;
  wire         hs_osc_ready_i;
  wire         ls_osc_ready_i;
  wire         ls_clk_i;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic [1:0]  hs_freq_sel_o;
  logic [2:0]  p;
  logic        pready_o, pslverr_o, er, hs_osc_en_o, ls_osc_en_o, sys_clk_tick_o, cpu_run_o, io_hold_o;
  logic        wdt_clear_o, wdt_run_o, pc_sp_reset_o, irq_service_o, resume_o;
  logic        power_down_flag_o, wdt_timeout_flag_o;
  int          bad_count = 0;
  int          comparisons = 0;
  int          n;
  row_t        r;
  int          tk[8] = '{128, 64, 32, 16, 8, 4, 2, 8};
  row_t        rows[5] = '{'{2'h0, 1'b0, 3'h0, 1'b0, 1'b0, 3'h1}, '{2'h1, 1'b1, 3'h1, 1'b0, 1'b1, 3'h4},
                           '{2'h3, 1'b1, 3'h2, 1'b1, 1'b1, 3'h2}, '{2'h2, 1'b0, 3'h3, 1'b1, 1'b0, 3'h1},
                           '{2'h0, 1'b1, 3'h4, 1'b0, 1'b1, 3'h1}};

  power_mode_switch_wakeup #(.PORTA_W(8), .IRQ_W(8), .STAB_CYC(2)) u_dut (.*);
  osc_model #(.RDY_CYC(6)) u_osc (.clk_i, .hs_en_i(hs_osc_en_o), .ls_en_i(ls_osc_en_o),
    .hs_ready_o(hs_osc_ready_i), .ls_ready_o(ls_osc_ready_i), .ls_clk_o(ls_clk_i));

  initial forever #25 clk_i = ~clk_i;

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Idle cycle before each setup keeps strobes from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_wake();
    p = 3'h0;
    for (int i = 0; i < 300 && p == 3'h0; i++) begin
      @(posedge clk_i);
      #1 p = {pc_sp_reset_o, irq_service_o, resume_o};
    end
  endtask

  task automatic do_reset();
    srst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    apb(1'b0, SYS_CLK_CTRL_OFS, 32'h0);
    chk("sysclk", rd, 32'h0);
    apb(1'b0, HS_OSC_CTRL_OFS, 32'h0);
    chk("hsosc", rd, 32'h3);
    apb(1'b0, PWR_STATUS_OFS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, MODE_STATE_OFS, 32'h0);
    chk("mode", rd, 32'h1);
    $display("test reset done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("ERROR watchdog expired");
    give_verdict();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    do_reset();
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, SYS_CLK_CTRL_OFS, {24'h0, s[2:0], 5'h0});
      repeat (40) @(posedge clk_i);
      n = 0;
      repeat (128) @(posedge clk_i) n += (sys_clk_tick_o === 1'b1);
      chk("ticks", n, tk[s]);
      apb(1'b0, SYS_CLK_CTRL_OFS, 32'h0);
      chk("sel_back", rd, {24'h0, s[2:0], 5'h0});
    end
    $display("test clock select done");
    // Back to fast with the fast oscillator stopped
    apb(1'b1, HS_OSC_CTRL_OFS, 32'h0);
    apb(1'b1, SYS_CLK_CTRL_OFS, 32'h0);
    apb(1'b0, HS_OSC_CTRL_OFS, 32'h0);
    chk("hs_wait", rd, 32'h0);
    for (int i = 0; i < 20 && rd[1] !== 1'b1; i++) apb(1'b0, HS_OSC_CTRL_OFS, 32'h0);
    chk("hs_up", rd, 32'h2);
    n = 0;
    repeat (128) @(posedge clk_i) n += (sys_clk_tick_o === 1'b1);
    chk("fast_ticks", n, 128);
    apb(1'b1, HS_OSC_CTRL_OFS, 32'h5);
    apb(1'b0, HS_OSC_CTRL_OFS, 32'h0);
    chk("fsel_clr", rd, 32'h5);
    chk("fsel", hs_freq_sel_o, 2'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    apb(1'b1, PWR_STATUS_OFS, 32'h3);
    apb(1'b0, PWR_STATUS_OFS, 32'h0);
    chk("status_ro", rd, 32'h0);
    apb(1'b1, PORTA_WAKE_OFS, 32'h1);
    // Clock enable low must freeze the system clock strobe
    ce_i <= 1'b0;
    n = 0;
    repeat (20) @(posedge clk_i) n += (sys_clk_tick_o === 1'b1);
    ce_i <= 1'b1;
    chk("ce_freeze", n, 0);
    $display("test switch and bus done");
    // Pending before entry, so it must never wake
    irq_req_i[7] <= 1'b1;
    irq_en_i[7] <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, SYS_CLK_CTRL_OFS, {30'h0, r.keep});
      wdt_enable_i <= r.we;
      @(posedge clk_i);
      halt_i <= 1'b1;
      @(posedge clk_i);
      halt_i <= 1'b0;
      wdt_overflow_i <= (r.wk == 3'h1);
      #1;
      chk("wdt_clear", wdt_clear_o, 1'b1);
      chk("entry_flags", {power_down_flag_o, wdt_timeout_flag_o}, 2'h2);
      chk("hold", {cpu_run_o, io_hold_o, wdt_run_o}, {2'h1, r.we});
      chk("osc", {hs_osc_en_o, ls_osc_en_o}, {r.hs, r.ls});
      @(posedge clk_i);
      wdt_overflow_i <= 1'b0;
      if (r.wk != 3'h1) begin
        porta_i[1] <= 1'b0;
        halt_i <= 1'b1;
        @(posedge clk_i);
        halt_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("asleep", cpu_run_o, 1'b0);
        porta_i[0] <= (r.wk != 3'h0);
        irq_req_i[2] <= (r.wk > 3'h1);
        irq_en_i[2] <= (r.wk != 3'h3);
        stack_full_i <= (r.wk == 3'h4);
      end
      wait_wake();
      chk("wake", p, r.pl);
      chk("after_wake", {cpu_run_o, power_down_flag_o, wdt_timeout_flag_o}, {2'h3, r.wk == 3'h1});
      porta_i <= 8'hff;
      irq_req_i[2] <= 1'b0;
      stack_full_i <= 1'b0;
      clr_wdt_i <= 1'b1;
      @(posedge clk_i);
      clr_wdt_i <= 1'b0;
      #1 chk("pd_clr", power_down_flag_o, 1'b0);
      $display("test mode row %0d done", i);
    end
    do_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
